// [hw/ssop_pkg.sv]
/*
 * ssop_pkg: register map, field layouts, timing constants and types of the
 * synchronous serial output port.
 * assumes a 25 MHz system clock and a classic wishbone register bus.
 */
// Overview of operation
// - port enable hands three segment pins to the serial port.
// - pins carry serial clock, data, frame pulse; fourth pin carries ready.
// - enabled port with lcd disabled owns the pins whatever lcd settings say.
// - fourth pin is ready output only with ready enable and port enable high.
// - otherwise the fourth pin stays an lcd segment driver.
// - serial clock runs at 5 MHz, or 10 MHz with speed bit set.
// - clock gating off: serial clock toggles continuously.
// - clock gating on: serial clock held low when no transfer runs.
// - frame pulse once per block, or every 8, 16 or 32 bits.
// - frame pulse positive with polarity bit 0, negative with 1.
package ssop_pkg;

    // ==========================================================
    // register map
    localparam logic [15:0] CTRL_ADDR  = 16'h2070;
    localparam logic [15:0] STAT_ADDR  = 16'h2074;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  CTRL_WMASK = 8'hFE;

    // ==========================================================
    // timing: half-periods come from a phase accumulator
    localparam int          CLK_HZ    = 25_000_000;
    localparam int          SLOW_HZ   = 5_000_000;
    localparam int          FAST_HZ   = 10_000_000;
    localparam int          ACC_UNIT  = 1_000_000;
    localparam logic [5:0]  ACC_MOD   = 6'(CLK_HZ / ACC_UNIT);
    localparam logic [5:0]  STEP_SLOW = 6'(2 * SLOW_HZ / ACC_UNIT);
    localparam logic [5:0]  STEP_FAST = 6'(2 * FAST_HZ / ACC_UNIT);

    // ==========================================================
    // frame spacing codes
    localparam logic [1:0]  FSP_BLOCK = 2'h0;
    localparam logic [1:0]  FSP_8     = 2'h1;
    localparam logic [1:0]  FSP_16    = 2'h2;
    localparam logic [1:0]  FSP_32    = 2'h3;

    // ==========================================================
    // types
    typedef struct packed {
        logic       port_enable;
        logic       clock_speed_select;
        logic       clock_gate_enable;
        logic [1:0] frame_spacing;
        logic       frame_polarity;
        logic       ready_pin_enable;
        logic       reserved;
    } ssop_ctrl_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } ssop_word_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ssop_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } ssop_state_t;

    // bit at block position pos opens a frame
    function automatic logic frame_start(input logic [1:0] fsp, input logic [4:0] pos, input logic head);
        case (fsp)
            FSP_BLOCK: frame_start = head;
            FSP_8:     frame_start = (pos[2:0] == 3'h0);
            FSP_16:    frame_start = (pos[3:0] == 4'h0);
            FSP_32:    frame_start = (pos == 5'h00);
            default:   frame_start = 1'b0;
        endcase
    endfunction : frame_start

endpackage : ssop_pkg

// [hw/ssop_rate.sv]
/*
 * ssop_rate: half-period tick source for the serial clock.
 * assumes the 25 MHz system clock; ticks jitter by one cycle, average exact.
 */
`timescale 1ns/1ns
module ssop_rate (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic fast,
    output logic      tick
);
    import ssop_pkg::*;

    logic [5:0] acc;
    logic [5:0] next_acc;
    logic       next_tick;
    logic [5:0] sum;

    // ==========================================================
    // accumulator
    // step against modulus
    always_comb begin
        sum       = acc + (fast ? STEP_FAST : STEP_SLOW);
        next_acc  = sum;
        next_tick = 1'b0;
        if (!run) begin
            next_acc = 6'h00;
        end else if (sum >= ACC_MOD) begin
            next_acc  = sum - ACC_MOD;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc  <= 6'h00;
            tick <= 1'b0;
        end else begin
            acc  <= next_acc;
            tick <= next_tick;
        end
    end

endmodule : ssop_rate

// [hw/ssop_fifo2.sv]
/*
 * ssop_fifo2: two-entry buffer with valid and ready on both sides.
 * assumes both sides run on the same clock.
 */
`timescale 1ns/1ns
module ssop_fifo2 #(
    parameter int W = 9
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem      [2];
    logic [W-1:0] next_mem [2];
    logic         wr;
    logic         next_wr;
    logic         rd;
    logic         next_rd;
    logic [1:0]   cnt;
    logic [1:0]   next_cnt;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data  = mem[rd];

    // ==========================================================
    // pointers and storage
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        next_mem = mem;
        if (push) begin
            next_mem[wr] = in_data;
        end
        next_wr  = wr ^ push;
        next_rd  = rd ^ pop;
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr  <= 1'b0;
            rd  <= 1'b0;
            cnt <= 2'h0;
        end else begin
            wr  <= next_wr;
            rd  <= next_rd;
            cnt <= next_cnt;
        end
        mem <= next_mem;
    end

endmodule : ssop_fifo2

// [hw/ssop_port.sv]
/*
 * ssop_port: serial output port top; wishbone registers, bit engine,
 * sharing of four segment pins with the lcd driver.
 * assumes source words and lcd pin levels come from logic on CLK_SYS.
 */
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module ssop_port (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    input  wire logic [15:0]          WB_ADR_I,
    input  wire logic [31:0]          WB_DAT_I,
    output logic [31:0]               WB_DAT_O,
    input  wire logic [3:0]           WB_SEL_I,
    input  wire logic                 WB_WE_I,
    input  wire logic                 WB_CYC_I,
    input  wire logic                 WB_STB_I,
    output logic                      WB_ACK_O,
    input  wire ssop_pkg::ssop_word_t SRC_WORD,
    input  wire logic                 SRC_VALID,
    output logic                      SRC_READY,
    input  wire logic                 LCD_ENABLE,
    input  wire ssop_pkg::ssop_pins_t LCD_SEG,
    output ssop_pkg::ssop_pins_t      SEG_OUT
);
    import ssop_pkg::*;

    ssop_ctrl_t  ctrl;
    ssop_ctrl_t  next_ctrl;
    logic        ack;
    logic        next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [3:0]  status;

    ssop_state_t state;
    ssop_state_t next_state;
    logic        sclk;
    logic        next_sclk;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic        dout;
    logic        next_dout;
    logic        last_byte;
    logic        next_last;
    logic [2:0]  bit_idx;
    logic [2:0]  next_bit_idx;
    logic [4:0]  blk_pos;
    logic [4:0]  next_blk_pos;
    logic        head;
    logic        next_head;
    logic        blk_new;
    logic        next_blk_new;
    logic        frame_on;
    logic        next_frame_on;
    logic [4:0]  pos_n;
    logic        new_n;

    ssop_pins_t  seg;
    ssop_pins_t  next_seg;
    logic        tick;
    logic        present;
    logic        take;
    logic        buf_valid;
    ssop_word_t  buf_word;
    logic        ready_level;

    assign WB_DAT_O    = rdata;
    assign WB_ACK_O    = ack;
    assign SEG_OUT     = seg;
    assign ready_level = (state == ST_SHIFT) || buf_valid;
    assign status      = {ready_level, buf_valid, ctrl.port_enable & LCD_ENABLE, state == ST_SHIFT};

    // ==========================================================
    // register bus
    always_comb begin
        next_ctrl  = ctrl;
        next_ack   = 1'b0;
        next_rdata = 32'h0000_0000;
        if (WB_CYC_I && WB_STB_I && !ack) begin
            next_ack = 1'b1;
            case (WB_ADR_I)
                CTRL_ADDR: begin
                    next_rdata = {24'h00_0000, ctrl};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        next_ctrl = ssop_ctrl_t'(WB_DAT_I[7:0] & CTRL_WMASK);
                    end
                end
                STAT_ADDR: begin
                    next_rdata = {28'h000_0000, status};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl  <= ssop_ctrl_t'(CTRL_RESET);
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ctrl  <= next_ctrl;
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // rate and buffer
    ssop_rate u_rate (
        .clk  (CLK_SYS),
        .rst  (RST),
        .run  (ctrl.port_enable),
        .fast (ctrl.clock_speed_select),
        .tick (tick)
    );

    // a receiver stall only holds the source off, no word lost
    ssop_fifo2 #(.W($bits(ssop_word_t))) u_buf (
        .clk       (CLK_SYS),
        .rst       (RST),
        .in_valid  (SRC_VALID),
        .in_ready  (SRC_READY),
        .in_data   (SRC_WORD),
        .out_valid (buf_valid),
        .out_ready (take),
        .out_data  (buf_word)
    );

    // ==========================================================
    // bit engine: data changes on falling edge, receiver samples rising
    // fall point each second tick, or every tick while gated and idle
    assign present = tick && (sclk || (ctrl.clock_gate_enable && state == ST_IDLE));

    always_comb begin
        next_state    = state;
        next_sclk     = sclk;
        next_shreg    = shreg;
        next_dout     = dout;
        next_last     = last_byte;
        next_bit_idx  = bit_idx;
        next_blk_pos  = blk_pos;
        next_head     = head;
        next_blk_new  = blk_new;
        next_frame_on = frame_on;
        pos_n         = blk_pos;
        new_n         = blk_new;
        take          = 1'b0;
        if (!ctrl.port_enable) begin
            next_state    = ST_IDLE;
            next_sclk     = 1'b0;
            next_dout     = 1'b0;
            next_bit_idx  = 3'h0;
            next_blk_pos  = 5'h00;
            next_head     = 1'b0;
            next_blk_new  = 1'b1;
            next_frame_on = 1'b0;
        end else if (present) begin
            next_sclk = 1'b0;
            if (state == ST_SHIFT && bit_idx != 3'h7) begin
                next_shreg    = {shreg[6:0], 1'b0};
                next_dout     = shreg[6];
                next_bit_idx  = bit_idx + 3'h1;
                next_blk_pos  = blk_pos + 5'h01;
                next_head     = 1'b0;
                next_frame_on = frame_start(ctrl.frame_spacing, blk_pos + 5'h01, 1'b0);
            end else begin
                if (state == ST_SHIFT) begin
                    pos_n = blk_pos + 5'h01;
                    new_n = last_byte;
                end
                if (new_n) begin
                    pos_n = 5'h00;
                end
                next_blk_pos = pos_n;
                next_blk_new = new_n;
                if (buf_valid) begin
                    take          = 1'b1;
                    next_state    = ST_SHIFT;
                    next_shreg    = buf_word.data;
                    next_dout     = buf_word.data[7];
                    next_last     = buf_word.last;
                    next_bit_idx  = 3'h0;
                    next_head     = new_n;
                    next_blk_new  = 1'b0;
                    // frame at block or word start
                    next_frame_on = frame_start(ctrl.frame_spacing, pos_n, new_n);
                end else begin
                    // underrun: a block resumes where it stopped
                    next_state    = ST_IDLE;
                    next_head     = 1'b0;
                    next_frame_on = 1'b0;
                end
            end
        end else if (ctrl.clock_gate_enable && state == ST_IDLE) begin
            next_sclk = 1'b0;
        end else if (tick) begin
            next_sclk = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state     <= ST_IDLE;
            sclk      <= 1'b0;
            shreg     <= 8'h00;
            dout      <= 1'b0;
            last_byte <= 1'b0;
            bit_idx   <= 3'h0;
            blk_pos   <= 5'h00;
            head      <= 1'b0;
            blk_new   <= 1'b1;
            frame_on  <= 1'b0;
        end else begin
            state     <= next_state;
            sclk      <= next_sclk;
            shreg     <= next_shreg;
            dout      <= next_dout;
            last_byte <= next_last;
            bit_idx   <= next_bit_idx;
            blk_pos   <= next_blk_pos;
            head      <= next_head;
            blk_new   <= next_blk_new;
            frame_on  <= next_frame_on;
        end
    end

    // ==========================================================
    // pin sharing; lcd enable is only reported, software avoids the clash
    always_comb begin
        next_seg = LCD_SEG;
        if (ctrl.port_enable) begin
            next_seg.a = sclk;
            next_seg.b = dout;
            next_seg.c = frame_on ^ ctrl.frame_polarity;
        end
        if (ctrl.port_enable && ctrl.ready_pin_enable) begin
            next_seg.d = ready_level;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            seg <= '0;
        end else begin
            seg <= next_seg;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    property p_pins_serial;
        ctrl.port_enable |=> SEG_OUT.a == $past(sclk) && SEG_OUT.b == $past(dout);
    endproperty
    a_pins_serial: assert property (p_pins_serial) else $error("serial pins not driven by engine");

    property p_over_lcd;
        ctrl.port_enable && !LCD_ENABLE ##1 ctrl.port_enable |-> SEG_OUT.a == $past(sclk);
    endproperty
    a_over_lcd: assert property (p_over_lcd) else $error("lcd kept the clock pin");

    property p_ready_pin;
        ctrl.port_enable && ctrl.ready_pin_enable |=> SEG_OUT.d == $past(ready_level);
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready pin wrong");

    property p_ready_lcd;
        !(ctrl.port_enable && ctrl.ready_pin_enable) |=> SEG_OUT.d == $past(LCD_SEG.d);
    endproperty
    a_ready_lcd: assert property (p_ready_lcd) else $error("fourth pin left lcd");

    property p_rate_slow;
        ctrl.port_enable && !ctrl.clock_speed_select && !$past(ctrl.clock_speed_select) && tick
            ##1 !ctrl.clock_speed_select |-> !tick;
    endproperty
    a_rate_slow: assert property (p_rate_slow) else $error("slow ticks too dense");

    property p_rate_fast;
        ctrl.port_enable && ctrl.clock_speed_select && $past(ctrl.port_enable) && !tick
            ##1 ctrl.clock_speed_select |-> tick;
    endproperty
    a_rate_fast: assert property (p_rate_fast) else $error("fast ticks too sparse");

    property p_continuous;
        ctrl.port_enable && !ctrl.clock_gate_enable && tick ##1 ctrl.port_enable |-> sclk != $past(sclk);
    endproperty
    a_continuous: assert property (p_continuous) else $error("free clock missed a toggle");

    property p_gated;
        ctrl.clock_gate_enable && state == ST_IDLE ##1 ctrl.clock_gate_enable && state == ST_IDLE |-> !sclk;
    endproperty
    a_gated: assert property (p_gated) else $error("gated clock ran while idle");

    property p_frame;
        state == ST_SHIFT && $stable(ctrl.frame_spacing)
            |-> frame_on == frame_start(ctrl.frame_spacing, blk_pos, head);
    endproperty
    a_frame: assert property (p_frame) else $error("frame pulse misplaced");

    property p_polarity;
        ctrl.port_enable |=> SEG_OUT.c == ($past(frame_on) ^ $past(ctrl.frame_polarity));
    endproperty
    a_polarity: assert property (p_polarity) else $error("frame polarity wrong");

    property p_off;
        !ctrl.port_enable |=> state == ST_IDLE && !sclk && !frame_on && !take;
    endproperty
    a_off: assert property (p_off) else $error("disabled port active");

    c_block_end: cover property (state == ST_SHIFT && last_byte ##[1:200] state == ST_IDLE);
    c_frame8: cover property (frame_on && ctrl.frame_spacing == FSP_8 && !head);
    c_buf_full: cover property (!SRC_READY && ctrl.port_enable);

endmodule : ssop_port

// [verification/ssop_rx_model.sv]
/*
 * ssop_rx_model: passive receiver watching the serial pins of the port.
 * assumes the pins are sampled on the system clock, which runs at least 2.5 times faster than the serial clock.
 */
`timescale 1ns/1ns
module ssop_rx_model (
    input  wire logic clk,
    input  wire logic sclk,
    input  wire logic sdata,
    input  wire logic frame,
    input  wire logic pol
);
    // ==========================================================
    // capture state
    logic       sclk_q = 1'b0;
    logic [7:0] shreg  = 8'h00;
    int         nbits  = 0;
    int         rises  = 0;
    int         frames = 0;
    logic [7:0] bytes[$];

    // call off the clock edge, or the sampler may see a half-cleared state
    task automatic clear();
        bytes.delete();
        nbits = 0;
        rises = 0;
        frames = 0;
    endtask : clear

    // ==========================================================
    // sampler: data and frame are taken on the rising serial edge
    always @(posedge clk) begin
        sclk_q <= sclk;
        if (sclk === 1'b1 && sclk_q === 1'b0) begin
            rises <= rises + 1;
            shreg <= {shreg[6:0], sdata};
            if ((frame ^ pol) === 1'b1) begin
                frames <= frames + 1;
            end
            if (nbits == 7) begin
                bytes.push_back({shreg[6:0], sdata});
                nbits <= 0;
            end else begin
                nbits <= nbits + 1;
            end
        end
    end
endmodule : ssop_rx_model

// [verification/tb.sv]
/*
 * tb: self-checking bench for ssop_port; wishbone tasks, source feeder, receiver model.
 * assumes ssop_pkg, the design files and ssop_rx_model are compiled before it.
 */
`timescale 1ns/1ns
module tb;
    import ssop_pkg::*;

    // ==========================================================
    // signals
    logic        CLK_SYS, RST, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O;
    logic [15:0] WB_ADR_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic [3:0]  WB_SEL_I;
    ssop_word_t  SRC_WORD;
    logic        SRC_VALID, SRC_READY, LCD_ENABLE, pol_cfg;
    ssop_pins_t  LCD_SEG, SEG_OUT;
    int          n_fail, tests_run, hi, exp_n;
    logic [7:0]  pat [4] = '{8'h96, 8'h0F, 8'hC3, 8'h5A};

    always #20 CLK_SYS = ~CLK_SYS;

    ssop_port i_ssop_port (.CLK_SYS(CLK_SYS), .RST(RST), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SRC_WORD(SRC_WORD), .SRC_VALID(SRC_VALID),
        .SRC_READY(SRC_READY), .LCD_ENABLE(LCD_ENABLE), .LCD_SEG(LCD_SEG), .SEG_OUT(SEG_OUT));
    ssop_rx_model i_ssop_rx_model (.clk(CLK_SYS), .sclk(SEG_OUT.a), .sdata(SEG_OUT.b),
        .frame(SEG_OUT.c), .pol(pol_cfg));

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // request held up to the rising edge that samples ack; read data taken at that edge
    task automatic wb_cycle(input logic [15:0] adr, input logic we, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        WB_ADR_I <= adr;
        WB_WE_I <= we;
        WB_DAT_I <= dat;
        WB_SEL_I <= 4'hF;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 50);
        q = WB_DAT_O;
        if (n >= 50) n_fail++;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        @(posedge CLK_SYS);
    endtask : wb_cycle

    task automatic wb_read(input logic [15:0] adr, input logic [31:0] exp, input string what);
        wb_cycle(adr, 1'b0, 32'h0, rd);
        check(what, rd, exp);
    endtask : wb_read

    // leaves valid high so back-to-back words need no gap
    task automatic send_word(input logic [7:0] d, input logic last);
        int n;
        n = 0;
        SRC_WORD <= '{last: last, data: d};
        SRC_VALID <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (SRC_READY !== 1'b1 && n < 400);
        if (n >= 400) n_fail++;
    endtask : send_word

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb_cycle(STAT_ADDR, 1'b0, 32'h0, rd);
            n++;
        end while ((rd & 32'h5) !== 32'h0 && n < 400);
        check("idle reached", 32'(n < 400), 32'h1);
        repeat (4) @(posedge CLK_SYS);
    endtask : wait_idle

    // ==========================================================
    // watchdog, far beyond the 1200 or so cycles the tests need
    initial begin
        #(40 * 60000);
        n_fail++;
        final_report();
    end

    // ==========================================================
    // tests
    initial begin
        CLK_SYS = 1'b0;
        RST = 1'b1;
        {WB_WE_I, WB_CYC_I, WB_STB_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} = '0;
        SRC_WORD = '0;
        SRC_VALID = 1'b0;
        LCD_ENABLE = 1'b0;
        LCD_SEG = '0;
        pol_cfg = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        wb_read(CTRL_ADDR, {24'h0, CTRL_RESET}, "ctrl reset");
        wb_cycle(CTRL_ADDR, 1'b1, 32'h7F, rd);
        wb_read(CTRL_ADDR, 32'h7E, "ctrl readback");
        wb_cycle(16'h2100, 1'b1, 32'hFF, rd);
        wb_cycle(STAT_ADDR, 1'b1, 32'hFF, rd);
        wb_read(16'h2100, 32'h0, "unmapped read");
        wb_cycle(CTRL_ADDR, 1'b1, 32'h0, rd);
        wb_read(STAT_ADDR, 32'h0, "status idle");
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            LCD_SEG <= 4'(i);
            @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            check("lcd passthrough", {28'h0, SEG_OUT}, 32'(i));
            @(posedge CLK_SYS);
        end
        send_word(8'hA5, 1'b0);
        send_word(8'h3C, 1'b1);
        SRC_VALID <= 1'b0;
        repeat (20) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check("buffer full", {31'h0, SRC_READY}, 32'h0);
        check("pins idle while off", {28'h0, SEG_OUT}, 32'hF);
        i_ssop_rx_model.clear();
        @(posedge CLK_SYS);
        $display("test disabled port done");
        // slow, gated, block framing, positive, ready pin on
        wb_cycle(CTRL_ADDR, 1'b1, 32'hA2, rd);
        wait_idle();
        check("byte count", i_ssop_rx_model.bytes.size(), 32'h2);
        check("byte 0", i_ssop_rx_model.bytes[0], 32'hA5);
        check("byte 1", i_ssop_rx_model.bytes[1], 32'h3C);
        check("block frames", i_ssop_rx_model.frames, 32'h1);
        hi = 0;
        for (int i = 0; i < 50; i++) begin
            @(negedge CLK_SYS);
            hi += int'(SEG_OUT.a);
        end
        check("gated clock idle", hi, 32'h0);
        check("ready idle low", {31'h0, SEG_OUT.d}, 32'h0);
        @(posedge CLK_SYS);
        $display("test drain done");
        for (int c = 0; c < 4; c++) begin
            pol_cfg <= c[0];
            @(negedge CLK_SYS);
            i_ssop_rx_model.clear();
            @(posedge CLK_SYS);
            wb_cycle(CTRL_ADDR, 1'b1, {24'h0, 1'b1, c[1], 1'b1, c[1:0], c[0], 2'b10}, rd);
            for (int k = 0; k < 4; k++) begin
                send_word(pat[k], k == 3);
            end
            SRC_VALID <= 1'b0;
            @(negedge CLK_SYS);
            check("ready while busy", {31'h0, SEG_OUT.d}, 32'h1);
            @(posedge CLK_SYS);
            wait_idle();
            for (int k = 0; k < 4; k++) begin
                check("block byte", i_ssop_rx_model.bytes[k], {24'h0, pat[k]});
            end
            exp_n = (c == 0) ? 1 : 32 >> (c + 2);
            check("frame pulses", i_ssop_rx_model.frames, exp_n);
            $display("test framing code %0d done", c);
        end
        for (int s = 0; s < 2; s++) begin
            wb_cycle(CTRL_ADDR, 1'b1, {24'h0, 1'b1, s[0], 6'h00}, rd);
            repeat (10) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            i_ssop_rx_model.clear();
            repeat (200) @(negedge CLK_SYS);
            exp_n = 200 * ((s != 0 ? FAST_HZ : SLOW_HZ) / 1000) / (CLK_HZ / 1000);
            hi = i_ssop_rx_model.rises;
            check("clock rate", 32'(hi >= exp_n - 1 && hi <= exp_n + 1), 32'h1);
            check("fourth pin lcd", {31'h0, SEG_OUT.d}, 32'h1);
            @(posedge CLK_SYS);
        end
        $display("test free clock done");
        wb_cycle(CTRL_ADDR, 1'b1, 32'h0, rd);
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check("pins back to lcd", {28'h0, SEG_OUT}, 32'hF);
        $display("test disable done");
        @(posedge CLK_SYS);
        final_report();
    end
endmodule : tb
